// ===== shared/tcsc_pkg.sv
// constants, register map and types of the timer clock select counter
package tcsc_pkg;
  // register byte addresses (index times four)
  localparam logic [7:0] TCSC_IDX_CLK_CTRL = 8'h33;
  localparam logic [11:0] TCSC_ADDR_CLK_CTRL = 12'h0CC;
  localparam logic [11:0] TCSC_ADDR_CTRL_A = 12'h000;
  localparam logic [11:0] TCSC_ADDR_CNT_LO = 12'h004;
  localparam logic [11:0] TCSC_ADDR_CNT_HI = 12'h008;
  localparam logic [11:0] TCSC_ADDR_CMP_A = 12'h00C;
  localparam logic [11:0] TCSC_ADDR_CMP_B = 12'h010;
  localparam logic [11:0] TCSC_ADDR_FLAGS = 12'h014;
  localparam logic [11:0] TCSC_ADDR_MASK = 12'h018;
  localparam int TCSC_ADDR_W = 12;

  // clock control field positions
  localparam int TCSC_SYNC_HOLD_BIT = 4;
  localparam int TCSC_PSC_CLEAR_BIT = 3;
  localparam logic [7:0] TCSC_CLK_CTRL_RST = 8'h00;

  // control a field positions
  localparam int TCSC_CAPEN_BIT = 2;
  localparam int TCSC_WIDTH_BIT = 1;
  localparam int TCSC_WAVE_BIT = 0;

  // flag register positions
  localparam int TCSC_OVF_BIT = 0;
  localparam int TCSC_CMPA_BIT = 1;
  localparam int TCSC_CMPB_BIT = 2;
  localparam int TCSC_CAP_BIT = 3;

  localparam logic [15:0] TCSC_MAX8 = 16'h00FF;
  localparam logic [15:0] TCSC_MAX16 = 16'hFFFF;

  // prescaler tap positions (divide by 8, 64, 256, 1024)
  localparam int TCSC_PSC_W = 10;
  localparam logic [9:0] TCSC_DIV8_MASK = 10'h007;
  localparam logic [9:0] TCSC_DIV64_MASK = 10'h03F;
  localparam logic [9:0] TCSC_DIV256_MASK = 10'h0FF;
  localparam logic [9:0] TCSC_DIV1024_MASK = 10'h3FF;

  typedef enum logic [2:0] {
    TCSC_SRC_STOP = 3'h0,
    TCSC_SRC_DIRECT = 3'h1,
    TCSC_SRC_DIV8 = 3'h2,
    TCSC_SRC_DIV64 = 3'h3,
    TCSC_SRC_DIV256 = 3'h4,
    TCSC_SRC_DIV1024 = 3'h5,
    TCSC_SRC_EXT_FALL = 3'h6,
    TCSC_SRC_EXT_RISE = 3'h7
  } tcsc_src_e;

  localparam logic [1:0] TCSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCSC_RESP_SLVERR = 2'h2;
endpackage

// ===== src/tcsc_pin_edge.sv
// count pin synchroniser and edge detector
`timescale 1ns/1ps
module tcsc_pin_edge
  import tcsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tcsc_edge_s;

  tcsc_edge_s state_reg;
  tcsc_edge_s state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.meta = pin_i;
    state_next.sync = state_reg.meta;
    state_next.prev = state_reg.sync;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // only the second and third stages feed the detector
  assign rise_o = state_reg.sync & ~state_reg.prev;
  assign fall_o = ~state_reg.sync & state_reg.prev;
endmodule // tcsc_pin_edge

// ===== src/tcsc_timer.sv
// timer clock select, prescaler and counter with axi4-lite registers
//
// Overview of operation
// - code 1 ticks every system clock
// - code 0 stops counting, registers stay accessible
// - codes 2..5 divide by 8,64,256,1024
// - code 6 falling, code 7 rising pin edges
// - prescaler free-running regardless of select
// - first divided count after 1..N clocks
// - pin sampled every clock by synchroniser
// - pin edge reaches counter in 2-3 clocks
// - pin ticks bypass the prescaler
// - sync hold keeps prescaler clear, halting timer
// - prescaler clear self-clears unless sync hold
// - pin counts even when driven as output
// - increment to TOP then restart at zero
// - maximum 0xFF or 0xFFFF by width
// - TOP is maximum or compare A by mode
// - cpu counter write beats clear and increment
// - overflow flag set on wrapping from maximum
// - 16-bit mode adds high byte, joins compares
// - four flags shared, individually maskable
// - overflow flag set in the wrapping tick
// - mode from capture, width and wave bits
`timescale 1ns/1ps
module tcsc_timer
  import tcsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_count_pin_i,
  input wire logic capture_event_i,
  input wire logic [TCSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TCSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_tick_o,
  output logic [3:0] irq_lines_o
);
  typedef struct packed {
    logic [TCSC_PSC_W-1:0] psc;
    logic sync_hold_mode;
    logic prescaler_clear;
    tcsc_src_e tick_source_select;
    logic [2:0] timer_control_a;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [3:0] timer_flag_reg;
    logic [3:0] timer_mask_reg;
    logic aw_held;
    logic [TCSC_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic tick;
  } tcsc_state_s;

  tcsc_state_s state_reg;
  tcsc_state_s state_next;

  logic pin_rise;
  logic pin_fall;

  tcsc_pin_edge u_pin_edge (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_count_pin_i),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // a tap fires when the low bits of the prescaler are all ones
  function automatic logic tap_hit(input logic [TCSC_PSC_W-1:0] p,
                                   input logic [TCSC_PSC_W-1:0] m);
    tap_hit = ((p & m) == m);
  endfunction

  function automatic logic addr_is(input logic [TCSC_ADDR_W-1:0] a,
                                   input logic [TCSC_ADDR_W-1:0] r);
    addr_is = (a == r);
  endfunction

  function automatic logic known_addr(input logic [TCSC_ADDR_W-1:0] a);
    known_addr = addr_is(a, TCSC_ADDR_CLK_CTRL) |
                 addr_is(a, TCSC_ADDR_CTRL_A) |
                 addr_is(a, TCSC_ADDR_CNT_LO) |
                 addr_is(a, TCSC_ADDR_CNT_HI) |
                 addr_is(a, TCSC_ADDR_CMP_A) |
                 addr_is(a, TCSC_ADDR_CMP_B) |
                 addr_is(a, TCSC_ADDR_FLAGS) |
                 addr_is(a, TCSC_ADDR_MASK);
  endfunction

  logic tick_raw;
  logic wide_mode;
  logic ctc_mode;
  logic [15:0] count_now;
  logic [15:0] count_max;
  logic [15:0] count_top;
  logic [15:0] count_inc;
  logic [15:0] cmp_word;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;
  logic [7:0] clk_ctrl_view;
  logic [3:0] flag_set;

  always_comb
  begin
    state_next = state_reg;

    // prescaler runs on its own; only the clear bit stops it
    if (state_reg.prescaler_clear)
      state_next.psc = '0;
    else
      state_next.psc = state_reg.psc + 1'b1;

    // tick selection; stop and halted prescaler give none
    case (state_reg.tick_source_select)
      TCSC_SRC_STOP: tick_raw = 1'b0;
      TCSC_SRC_DIRECT: tick_raw = 1'b1;
      TCSC_SRC_DIV8:
        tick_raw = tap_hit(state_reg.psc, TCSC_DIV8_MASK);
      TCSC_SRC_DIV64:
        tick_raw = tap_hit(state_reg.psc, TCSC_DIV64_MASK);
      TCSC_SRC_DIV256:
        tick_raw = tap_hit(state_reg.psc, TCSC_DIV256_MASK);
      TCSC_SRC_DIV1024:
        tick_raw = tap_hit(state_reg.psc, TCSC_DIV1024_MASK);
      TCSC_SRC_EXT_FALL: tick_raw = pin_fall;
      TCSC_SRC_EXT_RISE: tick_raw = pin_rise;
      default: tick_raw = 1'b0;
    endcase
    // halted by sync hold: divided taps frozen, as is the counter
    if (state_reg.prescaler_clear && state_reg.sync_hold_mode)
      tick_raw = 1'b0;
    state_next.tick = tick_raw;

    // mode decode
    wide_mode = state_reg.timer_control_a[TCSC_WIDTH_BIT];
    ctc_mode = ~state_reg.timer_control_a[TCSC_CAPEN_BIT] &
               ~wide_mode &
               state_reg.timer_control_a[TCSC_WAVE_BIT];
    count_now = wide_mode ?
                {state_reg.count_high_byte, state_reg.count_low_byte} :
                {8'h00, state_reg.count_low_byte};
    count_max = wide_mode ? TCSC_MAX16 : TCSC_MAX8;
    cmp_word = {state_reg.compare_b_value, state_reg.compare_a_value};
    count_top = ctc_mode ? {8'h00, state_reg.compare_a_value} :
                count_max;

    flag_set = '0;
    count_inc = count_now;
    if (tick_raw)
    begin
      if (count_now == count_top && ctc_mode)
        count_inc = '0;
      else
        count_inc = count_now + 16'h0001;
      if (count_now == count_max)
      begin
        count_inc = '0;
        flag_set[TCSC_OVF_BIT] = 1'b1;
      end
      if (wide_mode)
      begin
        if (count_now == cmp_word &&
            !state_reg.timer_control_a[TCSC_CAPEN_BIT])
          flag_set[TCSC_CMPA_BIT] = 1'b1;
      end
      else
      begin
        if (count_now[7:0] == state_reg.compare_a_value &&
            !state_reg.timer_control_a[TCSC_CAPEN_BIT])
          flag_set[TCSC_CMPA_BIT] = 1'b1;
        if (count_now[7:0] == state_reg.compare_b_value)
          flag_set[TCSC_CMPB_BIT] = 1'b1;
      end
    end
    state_next.count_low_byte = count_inc[7:0];
    if (wide_mode)
      state_next.count_high_byte = count_inc[15:8];

    // capture copies the counter into compare A, and its high byte into compare B in 16-bit mode
    if (capture_event_i && state_reg.timer_control_a[TCSC_CAPEN_BIT])
    begin
      state_next.compare_a_value = count_now[7:0];
      if (wide_mode)
        state_next.compare_b_value = count_now[15:8];
      flag_set[TCSC_CAP_BIT] = 1'b1;
    end

    // prescaler clear self-clears unless held
    if (!state_reg.sync_hold_mode)
      state_next.prescaler_clear = 1'b0;

    // axi write channels, taken in either order
    s_axi_awready = ~state_reg.aw_held & ~state_reg.bvalid;
    s_axi_wready = ~state_reg.w_held & ~state_reg.bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    wr_fire = state_reg.aw_held & state_reg.w_held;
    wbyte = state_reg.w_data[7:0];

    // flags: hardware set wins over write-one-to-clear
    state_next.timer_flag_reg = state_reg.timer_flag_reg;
    if (wr_fire && state_reg.w_strb[0] &&
        addr_is(state_reg.aw_addr, TCSC_ADDR_FLAGS))
      state_next.timer_flag_reg = state_reg.timer_flag_reg & ~wbyte[3:0];
    state_next.timer_flag_reg = state_next.timer_flag_reg | flag_set;

    if (wr_fire)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = known_addr(state_reg.aw_addr) ?
                         TCSC_RESP_OKAY : TCSC_RESP_SLVERR;
      if (state_reg.w_strb[0])
      begin
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_CLK_CTRL))
        begin
          state_next.sync_hold_mode = wbyte[TCSC_SYNC_HOLD_BIT];
          state_next.tick_source_select = tcsc_src_e'(wbyte[2:0]);
          // leaving sync hold releases the prescaler
          if (!wbyte[TCSC_SYNC_HOLD_BIT])
            state_next.prescaler_clear = 1'b0;
          else
            state_next.prescaler_clear = wbyte[TCSC_PSC_CLEAR_BIT];
          if (wbyte[TCSC_PSC_CLEAR_BIT])
            state_next.psc = '0;
        end
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_CTRL_A))
          state_next.timer_control_a = wbyte[2:0];
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_CNT_LO))
          state_next.count_low_byte = wbyte;
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_CNT_HI))
          state_next.count_high_byte = wbyte;
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_CMP_A))
          state_next.compare_a_value = wbyte;
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_CMP_B))
          state_next.compare_b_value = wbyte;
        if (addr_is(state_reg.aw_addr, TCSC_ADDR_MASK))
          state_next.timer_mask_reg = wbyte[3:0];
      end
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;

    // axi read channel
    clk_ctrl_view = {3'h0, state_reg.sync_hold_mode,
                     state_reg.prescaler_clear,
                     state_reg.tick_source_select};
    s_axi_arready = ~state_reg.rvalid;
    rd_fire = s_axi_arvalid & s_axi_arready;
    if (rd_fire)
    begin
      state_next.rvalid = 1'b1;
      state_next.rresp = known_addr(s_axi_araddr) ?
                         TCSC_RESP_OKAY : TCSC_RESP_SLVERR;
      state_next.rdata = '0;
      if (addr_is(s_axi_araddr, TCSC_ADDR_CLK_CTRL))
        state_next.rdata[7:0] = clk_ctrl_view;
      if (addr_is(s_axi_araddr, TCSC_ADDR_CTRL_A))
        state_next.rdata[2:0] = state_reg.timer_control_a;
      if (addr_is(s_axi_araddr, TCSC_ADDR_CNT_LO))
        state_next.rdata[7:0] = state_reg.count_low_byte;
      if (addr_is(s_axi_araddr, TCSC_ADDR_CNT_HI))
        state_next.rdata[7:0] = state_reg.count_high_byte;
      if (addr_is(s_axi_araddr, TCSC_ADDR_CMP_A))
        state_next.rdata[7:0] = state_reg.compare_a_value;
      if (addr_is(s_axi_araddr, TCSC_ADDR_CMP_B))
        state_next.rdata[7:0] = state_reg.compare_b_value;
      if (addr_is(s_axi_araddr, TCSC_ADDR_FLAGS))
        state_next.rdata[3:0] = state_reg.timer_flag_reg;
      if (addr_is(s_axi_araddr, TCSC_ADDR_MASK))
        state_next.rdata[3:0] = state_reg.timer_mask_reg;
    end
    else if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
      state_reg.tick_source_select <= TCSC_SRC_STOP;
    end
    else
      state_reg <= state_next;
  end

  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign timer_tick_o = state_reg.tick;
  // masked flag lines towards the cpu interrupt logic
  assign irq_lines_o = state_reg.timer_flag_reg &
                       state_reg.timer_mask_reg;
endmodule // tcsc_timer

// ===== testbench/tcsc_timer_monitor.sv
// port-level assertion checker for the timer
`timescale 1ns/1ps
module tcsc_timer_monitor
  import tcsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ext_count_pin_i,
  input wire logic [TCSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic timer_tick_o,
  input wire logic [3:0] irq_lines_o
);
  logic [4:0] ctl_reg;
  logic [3:0] msk_reg;
  logic [10:0] gap_reg;
  logic ok_reg, wr, wc, run, dir, div, ext;
  logic [1:0] wd_reg;
  logic [10:0] per;
  // shadow relies on address and data being taken in one cycle
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_wstrb[0];
  assign wc = wr && s_axi_awaddr == TCSC_ADDR_CLK_CTRL;
  assign run = ctl_reg[2:0] != 3'h0 && !ctl_reg[4];
  assign dir = run && ctl_reg[2:0] == 3'h1;
  assign div = run && ctl_reg[2:0] inside {[3'h2:3'h5]};
  assign ext = run && ctl_reg[2:1] == 2'h3;
  assign per = ctl_reg[1] ? (ctl_reg[0] ? 11'h040 : 11'h008)
    : (ctl_reg[0] ? 11'h400 : 11'h100);
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctl_reg <= 5'h00;
      msk_reg <= 4'h0;
      gap_reg <= 11'h000;
      ok_reg <= 1'h0;
      wd_reg <= 2'h0;
    end
    else
    begin
      if (wc)
        ctl_reg <= s_axi_wdata[4:0];
      if (wr && s_axi_awaddr == TCSC_ADDR_MASK)
        msk_reg <= s_axi_wdata[3:0];
      gap_reg <= timer_tick_o ? 11'h001 : gap_reg + 11'h001;
      wd_reg <= {wd_reg[0], wc};
      // a tick still in flight from the old source must not arm it
      ok_reg <= (wc || wd_reg != 2'h0) ? 1'h0 : (timer_tick_o || ok_reg);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow leads the registered tick by two edges
  a_direct_tick: assert property (dir [*3] |-> timer_tick_o)
    else $error("direct source missed a tick");
  a_stop_quiet: assert property (
    (ctl_reg[2:0] == 3'h0) [*3] |-> !timer_tick_o)
    else $error("tick while stopped");
  a_hold_quiet: assert property (
    (ctl_reg[4:3] == 2'h3) [*3] |-> !timer_tick_o)
    else $error("tick while sync hold set");
  a_tap_period: assert property (
    timer_tick_o && ok_reg && div |-> gap_reg == per)
    else $error("divided tick period wrong");
  a_first_count: assert property (
    wc && s_axi_wdata[2:0] == 3'h2 && !s_axi_wdata[4]
    |-> ##[3:10] timer_tick_o)
    else $error("first divided tick too late");
  a_pin_delay: assert property (
    $changed(ext_count_pin_i) && ext && ctl_reg[0] == ext_count_pin_i
    |-> ##[2:4] timer_tick_o)
    else $error("pin edge did not tick in time");
  a_pin_single: assert property (
    ext && timer_tick_o |=> !timer_tick_o)
    else $error("pin tick longer than one cycle");
  a_irq_masked: assert property (
    (irq_lines_o & ~msk_reg & ~$past(msk_reg)) == 4'h0)
    else $error("masked interrupt line raised");
endmodule // tcsc_timer_monitor

// ===== testbench/tcsc_pin_src.sv
// external count source driving the count pin
`timescale 1ns/1ps
module tcsc_pin_src
(
  input wire logic run_i,
  input wire logic [7:0] half_ns_i,
  output logic pin_o
);
  // pin moves while running and once more within half_ns_i after run_i falls, so it is stable around reconfig;
  // the offset keeps edges between clock edges for half periods of 4k ns
  initial
  begin
    pin_o = 1'h0;
    forever
    begin
      wait (run_i);
      #2;
      while (run_i)
      begin
        #(half_ns_i) pin_o = ~pin_o;
      end
    end
  end
endmodule // tcsc_pin_src

// ===== testbench/tcsc_timer_tb.sv
// self-checking bench for the timer
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %0t got %h exp %h", $time, a, e); \
    end \
  end
module tcsc_timer_tb
  import tcsc_pkg::*;
;
  logic clk_i, rst_n_i, ext_count_pin_i, run, capture_event_i;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q, keep_q;
  logic [3:0] s_axi_wstrb, irq_lines_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, timer_tick_o;
  logic [7:0] half_q;
  logic [2:0] mode_q;
  int err_count, checks, edges;
  int per[4] = '{8, 64, 256, 1024};
  tcsc_timer u_tcsc_timer (.*);
  tcsc_pin_src u_tcsc_pin_src (.run_i(run), .half_ns_i(half_q),
    .pin_o(ext_count_pin_i));
  initial
  begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end
  always @(ext_count_pin_i)
    if (ext_count_pin_i === mode_q[0])
      edges++;
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // requests change after a rising edge; answers taken at the rising edge
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    logic ha, hw, hr, hd;
    hd = 1'h0;
    if (w)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
    end
    while (!hd)
    begin
      @(posedge clk_i);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hr = s_axi_arvalid && s_axi_arready;
      hd = w ? s_axi_bvalid : s_axi_rvalid;
      rd_q = s_axi_rdata;
      rsp_q = w ? s_axi_bresp : s_axi_rresp;
      if (ha)
        s_axi_awvalid <= 1'h0;
      if (hw)
        s_axi_wvalid <= 1'h0;
      if (hr)
        s_axi_arvalid <= 1'h0;
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end
  initial
  begin
    {rst_n_i, run, capture_event_i, s_axi_awvalid} = 4'h0;
    {s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 4'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'h1;
    half_q = 8'h14;
    mode_q = 3'h0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    bus(0, TCSC_ADDR_CLK_CTRL, 8'h00);
    `CHK(rd_q, {24'h0, TCSC_CLK_CTRL_RST})
    bus(0, 12'h040, 8'h00);
    `CHK({rsp_q, rd_q}, {TCSC_RESP_SLVERR, 32'h0})
    bus(1, 12'h040, 8'hFF);
    `CHK(rsp_q, TCSC_RESP_SLVERR)
    bus(1, TCSC_ADDR_CNT_LO, 8'h10);
    bus(1, TCSC_ADDR_CLK_CTRL, 8'h19);
    idle(10);
    bus(0, TCSC_ADDR_CLK_CTRL, 8'h00);
    `CHK(rd_q, 32'h19)
    bus(0, TCSC_ADDR_CNT_LO, 8'h00);
    `CHK(rd_q, 32'h10)
    bus(1, TCSC_ADDR_CLK_CTRL, 8'h01);
    bus(0, TCSC_ADDR_CLK_CTRL, 8'h00);
    `CHK(rd_q, 32'h01)
    bus(1, TCSC_ADDR_CLK_CTRL, 8'h08);
    bus(0, TCSC_ADDR_CLK_CTRL, 8'h00);
    `CHK(rd_q, 32'h00)
    bus(0, TCSC_ADDR_CNT_LO, 8'h00);
    keep_q = rd_q;
    idle(20);
    bus(0, TCSC_ADDR_CNT_LO, 8'h00);
    `CHK(rd_q, keep_q)
    for (int w = 0; w < 2; w++)
    begin
      bus(1, TCSC_ADDR_CTRL_A, 8'(w << 1));
      bus(1, TCSC_ADDR_CNT_LO, 8'hFF);
      bus(1, TCSC_ADDR_CNT_HI, 8'h00);
      bus(1, TCSC_ADDR_FLAGS, 8'h0F);
      bus(1, TCSC_ADDR_MASK, 8'h01);
      bus(1, TCSC_ADDR_CLK_CTRL, 8'h01);
      bus(1, TCSC_ADDR_CLK_CTRL, 8'h00);
      bus(0, TCSC_ADDR_FLAGS, 8'h00);
      `CHK(rd_q[0], w == 0)
      `CHK(rd_q[2:1], w == 0 ? 2'h3 : 2'h0)
      `CHK(irq_lines_o, {3'h0, w == 0})
      bus(0, TCSC_ADDR_CNT_HI, 8'h00);
      `CHK(rd_q[7:0], 8'(w))
      bus(1, TCSC_ADDR_FLAGS, 8'h01);
      `CHK(irq_lines_o, 4'h0)
    end
    bus(1, TCSC_ADDR_CTRL_A, 8'h01);
    bus(1, TCSC_ADDR_CMP_A, 8'h03);
    bus(1, TCSC_ADDR_CNT_LO, 8'h00);
    bus(1, TCSC_ADDR_CLK_CTRL, 8'h01);
    idle(20);
    bus(1, TCSC_ADDR_CLK_CTRL, 8'h00);
    bus(0, TCSC_ADDR_CNT_LO, 8'h00);
    `CHK(rd_q <= 32'h3, 1'h1)
    bus(1, TCSC_ADDR_CTRL_A, 8'h00);
    for (int s = 2; s < 6; s++)
    begin
      bus(1, TCSC_ADDR_CNT_LO, 8'h00);
      bus(1, TCSC_ADDR_CLK_CTRL, 8'(s));
      idle(2 * per[s - 2]);
      bus(1, TCSC_ADDR_CLK_CTRL, 8'h00);
      bus(0, TCSC_ADDR_CNT_LO, 8'h00);
      `CHK(rd_q inside {[2:3]}, 1'h1)
    end
    bus(1, TCSC_ADDR_CTRL_A, 8'h04);
    bus(1, TCSC_ADDR_CNT_LO, 8'h55);
    capture_event_i <= 1'h1;
    @(posedge clk_i);
    capture_event_i <= 1'h0;
    bus(0, TCSC_ADDR_CMP_A, 8'h00);
    `CHK(rd_q, 32'h55)
    bus(0, TCSC_ADDR_FLAGS, 8'h00);
    `CHK(rd_q[TCSC_CAP_BIT], 1'h1)
    bus(1, TCSC_ADDR_CTRL_A, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      mode_q = 3'(6 + k % 2);
      half_q <= k < 2 ? 8'h14 : 8'h3C;
      bus(1, TCSC_ADDR_CLK_CTRL, 8'(mode_q));
      bus(1, TCSC_ADDR_CNT_LO, 8'h00);
      edges = 0;
      run <= 1'h1;
      idle(40);
      run <= 1'h0;
      idle(14);
      bus(0, TCSC_ADDR_CNT_LO, 8'h00);
      `CHK(rd_q, 32'(edges))
    end
    bus(1, TCSC_ADDR_CLK_CTRL, 8'h00);
    print_verdict();
  end
endmodule // tcsc_timer_tb
bind tcsc_timer tcsc_timer_monitor u_tcsc_timer_monitor (.*);
